// ==== design/dma_engine.sv ====
// chained dma engine moving words between local memory and remote memory
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// RL1: only whole aligned 32-bit words move
// RL2: 32-bit via page table, 64-bit via base
// RL3: job length 4 bytes to 256 kilobytes
// RL4: push and pull transfers both supported
// RL5: any error halts and flags error status
// RL6: single register job or chained jobs
// RL7: loop-back copies within local memory
// RL8: each job selects stream window itself
// RL9: optional irq per block, chain end, error
// RL10: status register shows progress and condition
// RL11: yield buses between packets of 64 bytes
// RL12: pulled data written with memory writes
// RL13: 64-byte packets only when both aligned
// RL14: software loads registers then command
// RL15: software maps page before 32-bit job
// RL16: software loads base before 64-bit job
// RL17: local address outside bridge range
// RL18: block holds local, remote, control, base
// RL19: blocks follow each other 16 bytes apart
// RL20: chain starts at list pointer
// RL21: end-of-chain bit stops block fetching
// RL22: software loads pointer then command
// RL23: active cleared after finish or halt
module dma_engine (
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [31:0]        reg_rdata,
    output dma_pkg::mem_req_t       mem_o,
    input  wire dma_pkg::rsp_t      mem_i,
    output dma_pkg::sci_req_t       sci_o,
    input  wire dma_pkg::rsp_t      sci_i,
    output logic      [11:0]        pt_index,
    input  wire logic [63:0]        pt_entry,
    output logic                    bus_hold,
    output logic                    xfer_engine_irq_flag
);
    import dma_pkg::*;

    state_t      st_q, st_d;
    logic [31:0] remote_q, local_q, ctrl_q, wbase_q, ptr_q, lptr_q;
    logic [16:0] remain_q;
    logic [4:0]  len_q;
    logic [3:0]  idx_q;
    logic [1:0]  fidx_q;
    logic        chain_q, active_q, err_q, done_q, irq_q;
    logic [31:0] rdata_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // register decode
    wire wr_cmd    = reg_wr && reg_addr == OFF_CMD;
    wire wr_status = reg_wr && reg_addr == OFF_STATUS;
    wire start     = wr_cmd && reg_wdata[CMD_EN] && !active_q;
    wire cfg_wr    = reg_wr && !active_q;

    // job decode
    wire pull = ctrl_q[CTRL_PULL];
    wire loop = ctrl_q[CTRL_LOOP];
    wire wide = ctrl_q[CTRL_WIDE];
    wire src_local = loop || !pull;
    wire dst_local = loop || pull;
    wire [31:0] off4 = {26'h0, idx_q, 2'b00};
    wire [31:0] cur_local  = local_q + off4;
    wire [31:0] cur_remote = remote_q + off4;
    wire [63:0] sci_addr_w = wide ? {wbase_q, cur_remote}
        : {pt_entry[63:PAGE_LSB], cur_remote[PAGE_LSB-1:0]};  // see RL2
    wire aligned = local_q[5:0] == 6'h00 && remote_q[5:0] == 6'h00;
    wire [16:0] job_words = {1'b0, ctrl_q[CTRL_CNT_HI:0]} + 17'h00001;
    // the count loads during setup, so size the first packet from the word
    wire [16:0] left_words = st_q == S_SETUP ? job_words : remain_q;
    wire [4:0] pkt_words = (aligned && left_words >= 17'h00010)
        ? PKT_BIG : PKT_SMALL;  // see RL13
    wire last_word = {1'b0, idx_q} == len_q - PKT_SMALL;

    // transfer handshakes
    wire rd_local  = st_q == S_READ && src_local;
    wire wr_local  = st_q == S_WRITE && dst_local;
    wire use_mem   = st_q == S_FETCH || rd_local || wr_local;
    wire use_sci   = (st_q == S_READ || st_q == S_WRITE) && !use_mem;
    wire ack       = use_mem ? mem_i.ack : (use_sci && sci_i.ack);
    wire xfer_err  = (use_mem && mem_i.err) || (use_sci && sci_i.err);
    wire [31:0] in_data = use_mem ? mem_i.rdata : sci_i.rdata;
    wire [31:0] buf_data;
    wire blk_end   = st_q == S_WRITE && ack && !xfer_err && last_word
        && remain_q == {12'h000, len_q};
    wire chain_end = blk_end && (!chain_q || ctrl_q[CTRL_EOC]);  // see RL21
    wire [31:0] fetch_addr = ptr_q + {28'h0, fidx_q, 2'b00};
    wire [31:0] dst_addr = loop ? cur_remote : cur_local;  // see RL7

    dma_pkt_buf u_buf (
        .ref_clk (ref_clk),
        .we      (st_q == S_READ && ack && !xfer_err),
        .waddr   (idx_q),
        .wdata   (in_data),
        .raddr   (idx_q),
        .rdata   (buf_data)
    );

    // word addresses only: low two bits are dropped on every port
    assign mem_o.req   = use_mem;  // see RL12
    assign mem_o.we    = wr_local;
    assign mem_o.addr  = st_q == S_FETCH ? {fetch_addr[31:2], 2'h0}
        : {(rd_local ? cur_local[31:2] : dst_addr[31:2]), 2'b00};  // see RL1
    assign mem_o.wdata = buf_data;
    assign sci_o.req   = use_sci;  // see RL4
    assign sci_o.we    = st_q == S_WRITE;
    assign sci_o.big   = len_q == PKT_BIG;
    assign sci_o.win   = ctrl_q[CTRL_WIN_LO+3:CTRL_WIN_LO];  // see RL8
    assign sci_o.cmb   = ctrl_q[CTRL_CMB_LO+2:CTRL_CMB_LO];
    assign sci_o.addr  = {sci_addr_w[63:2], 2'b00};
    assign sci_o.wdata = buf_data;
    assign pt_index    = cur_remote[PAGE_LSB+PT_IDX_W-1:PAGE_LSB];
    // dropping the hold lets other masters and inbound traffic in
    assign bus_hold    = active_q && st_q != S_YIELD;  // see RL11
    assign xfer_engine_irq_flag = irq_q;
    assign reg_rdata   = rdata_q;

    word_align_a: assert property ( // see RL1
        mem_o.req |-> mem_o.addr[1:0] == 2'h0)
        else $error("local address not word aligned");
    fetch_read_a: assert property ( // see RL18
        st_q == S_FETCH |-> mem_o.req && !mem_o.we)
        else $error("control block fetch is not a read");
    push_write_a: assert property ( // see RL4
        st_q == S_WRITE && !pull && !loop |-> sci_o.req && sci_o.we)
        else $error("pushed data not written to remote memory");
    pull_write_a: assert property ( // see RL12
        st_q == S_WRITE && pull |-> mem_o.req && mem_o.we)
        else $error("pulled data not written to local memory");
    big_pkt_a: assert property ( // see RL13
        sci_o.req && sci_o.big |-> aligned)
        else $error("64-byte packet on unaligned addresses");

    wire irq_set = (xfer_err && ctrl_q[CTRL_IRQ_ERR])
        || (blk_end && ctrl_q[CTRL_IRQ_BLK])
        || (chain_end && ctrl_q[CTRL_IRQ_END]);  // see RL9
    wire [31:0] status_w = {28'h0, irq_q, done_q, err_q, active_q};
    wire [31:0] rd_mux =
        reg_addr == OFF_REMOTE ? remote_q :
        reg_addr == OFF_LOCAL  ? local_q  :
        reg_addr == OFF_CTRL   ? ctrl_q   :
        reg_addr == OFF_CMD    ? {30'h0, chain_q, active_q} :
        reg_addr == OFF_WBASE  ? wbase_q  :
        reg_addr == OFF_LPTR   ? lptr_q   :
        reg_addr == OFF_STATUS ? status_w : RST_WORD;  // see RL10

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            S_IDLE:  if (start) begin
                st_d = reg_wdata[CMD_CHAIN] ? S_FETCH : S_SETUP;  // see RL6
            end
            S_FETCH: if (xfer_err) begin
                st_d = S_IDLE;
            end else if (ack && fidx_q == 2'd3) begin
                st_d = S_SETUP;
            end
            S_SETUP: st_d = S_READ;
            S_READ:  if (xfer_err) begin
                st_d = S_IDLE;  // see RL5
            end else if (ack && last_word) begin
                st_d = S_WRITE;
            end
            S_WRITE: if (xfer_err || chain_end) begin
                st_d = S_IDLE;
            end else if (blk_end) begin
                st_d = S_FETCH;
            end else if (ack && last_word) begin
                st_d = S_YIELD;
            end
            S_YIELD: st_d = S_READ;
            default: st_d = S_IDLE;
        endcase
    end

    yield_gap_a: assert property ( // see RL11
        st_q == S_WRITE && ack && last_word && !blk_end && !xfer_err
        |=> !bus_hold ##1 bus_hold)
        else $error("no one-cycle yield between packets");

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_q <= S_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // job registers: written by software when idle or by block fetch; local and remote advance after each packet
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            remote_q <= RST_WORD;
            local_q  <= RST_WORD;
            ctrl_q   <= RST_WORD;
            wbase_q  <= RST_WORD;
            lptr_q   <= RST_WORD;
        end else if (st_q == S_FETCH && ack && !xfer_err) begin
            unique case (fidx_q)  // see RL18
                2'd0: local_q  <= mem_i.rdata;
                2'd1: remote_q <= mem_i.rdata;
                2'd2: ctrl_q   <= mem_i.rdata;
                2'd3: wbase_q  <= mem_i.rdata;
            endcase
        end else if (st_q == S_WRITE && ack && !xfer_err && last_word) begin
            local_q  <= local_q + {25'h0, len_q, 2'b00};
            remote_q <= remote_q + {25'h0, len_q, 2'b00};
        end else if (cfg_wr) begin
            if (reg_addr == OFF_REMOTE) remote_q <= reg_wdata;
            if (reg_addr == OFF_LOCAL)  local_q  <= reg_wdata;
            if (reg_addr == OFF_CTRL)   ctrl_q   <= reg_wdata;
            if (reg_addr == OFF_WBASE)  wbase_q  <= reg_wdata;
            if (reg_addr == OFF_LPTR)   lptr_q   <= reg_wdata;
        end
    end

    // progress counters
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ptr_q    <= RST_WORD;
            fidx_q   <= 2'd0;
            idx_q    <= 4'h0;
            len_q    <= PKT_SMALL;
            remain_q <= 17'h00000;
        end else begin
            if (start) begin
                ptr_q  <= lptr_q;  // see RL20
                fidx_q <= 2'd0;
            end else if (st_q == S_FETCH && ack) begin
                fidx_q <= fidx_q + 2'd1;
                if (fidx_q == 2'd3) begin
                    ptr_q <= ptr_q + BLOCK_STRIDE;  // see RL19
                end
            end
            if (st_q == S_SETUP) begin
                remain_q <= job_words;  // see RL3
            end else if (st_q == S_WRITE && ack && last_word) begin
                remain_q <= remain_q - {12'h000, len_q};
            end
            if (st_q == S_SETUP || st_q == S_YIELD) begin
                len_q <= pkt_words;
                idx_q <= 4'h0;
            end else if (ack && st_q != S_FETCH) begin
                idx_q <= last_word ? 4'h0 : idx_q + 4'h1;
            end
        end
    end

    chain_step_a: assert property ( // see RL19
        st_q == S_FETCH && ack && fidx_q == 2'h3 && !xfer_err
        |=> ptr_q == $past(ptr_q) + BLOCK_STRIDE)
        else $error("control block pointer did not advance 16");
    chain_start_a: assert property ( // see RL20
        start && reg_wdata[CMD_CHAIN]
        |=> st_q == S_FETCH && ptr_q == $past(lptr_q))
        else $error("chain did not start at list pointer");

    // status flags; a new event wins over a clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            active_q <= 1'b0;
            chain_q  <= 1'b0;
            err_q    <= 1'b0;
            done_q   <= 1'b0;
            irq_q    <= 1'b0;
            rdata_q  <= RST_WORD;
        end else begin
            rdata_q <= reg_rd ? rd_mux : RST_WORD;
            if (start) begin
                active_q <= 1'b1;
                chain_q  <= reg_wdata[CMD_CHAIN];
                err_q    <= 1'b0;
                done_q   <= 1'b0;
            end else if (xfer_err || chain_end) begin
                active_q <= 1'b0;  // see RL23
                err_q    <= xfer_err;
                done_q   <= !xfer_err;
            end
            if (irq_set) begin
                irq_q <= 1'b1;
            end else if (wr_status && reg_wdata[ST_IRQ]) begin
                irq_q <= 1'b0;
            end
        end
    end

    err_halt_a: assert property ( // see RL5
        xfer_err && active_q |=> !active_q && err_q && st_q == S_IDLE)
        else $error("engine kept running after an error");
    idle_active_a: assert property ( // see RL23
        active_q == (st_q != S_IDLE))
        else $error("active flag disagrees with engine state");
    eoc_stop_a: assert property ( // see RL21
        chain_end |=> st_q == S_IDLE && !mem_o.req && !sci_o.req)
        else $error("engine fetched past end of chain");
    end_irq_a: assert property ( // see RL9
        chain_end && ctrl_q[CTRL_IRQ_END] |=> irq_q && done_q)
        else $error("chain end did not raise interrupt flag");
    status_rd_a: assert property ( // see RL10
        reg_rd && reg_addr == OFF_STATUS
        |=> reg_rdata[ST_ACTIVE] == $past(active_q))
        else $error("status read shows wrong activity");
endmodule
`default_nettype wire

// ==== design/dma_pkg.sv ====
// shared constants, register map and carrier types of the chained dma engine
`default_nettype none
package dma_pkg;
    // register offsets (byte addresses on the register port)
    localparam logic [7:0] OFF_REMOTE = 8'h00;
    localparam logic [7:0] OFF_LOCAL  = 8'h04;
    localparam logic [7:0] OFF_CTRL   = 8'h08;
    localparam logic [7:0] OFF_CMD    = 8'h0C;
    localparam logic [7:0] OFF_WBASE  = 8'h10;
    localparam logic [7:0] OFF_LPTR   = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;

    // control word fields
    localparam int CTRL_CNT_HI  = 15;  // word count minus one, 1..65536 words
    localparam int CTRL_PULL    = 16;
    localparam int CTRL_LOOP    = 17;
    localparam int CTRL_WIN_LO  = 18;  // 4-bit window select
    localparam int CTRL_CMB_LO  = 22;  // 3-bit stream combining level
    localparam int CTRL_WIDE    = 25;  // 64-bit address mode
    localparam int CTRL_IRQ_BLK = 26;
    localparam int CTRL_IRQ_END = 27;
    localparam int CTRL_IRQ_ERR = 28;
    localparam int CTRL_EOC     = 29;

    // command and status fields
    localparam int CMD_EN      = 0;
    localparam int CMD_CHAIN   = 1;
    localparam int ST_ACTIVE   = 0;
    localparam int ST_ERROR    = 1;
    localparam int ST_DONE     = 2;
    localparam int ST_IRQ      = 3;

    // control block layout and packet sizes
    localparam logic [31:0] BLOCK_STRIDE = 32'h0000_0010;
    localparam logic [4:0]  PKT_BIG      = 5'h10;  // 16 words, 64 bytes
    localparam logic [4:0]  PKT_SMALL    = 5'h01;
    localparam int          PAGE_LSB     = 12;
    localparam int          PT_IDX_W     = 12;
    localparam logic [31:0] RST_WORD     = 32'h0000_0000;

    typedef enum logic [5:0] {
        S_IDLE  = 6'b000001,
        S_FETCH = 6'b000010,
        S_SETUP = 6'b000100,
        S_READ  = 6'b001000,
        S_WRITE = 6'b010000,
        S_YIELD = 6'b100000
    } state_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic        big;
        logic [3:0]  win;
        logic [2:0]  cmb;
        logic [63:0] addr;
        logic [31:0] wdata;
    } sci_req_t;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [31:0] rdata;
    } rsp_t;
endpackage
`default_nettype wire

// ==== design/dma_pkt_buf.sv ====
// sixteen-word packet staging buffer between source and destination
`timescale 1ns/1ns
`default_nettype none
module dma_pkt_buf (
    input  wire logic        ref_clk,
    input  wire logic        we,
    input  wire logic [3:0]  waddr,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  raddr,
    output logic      [31:0] rdata
);
    logic [31:0] mem_q [16];

    // no reset: contents are always written before they are read
    always_ff @(posedge ref_clk) begin
        if (we) begin
            mem_q[waddr] <= wdata;
        end
    end

    assign rdata = mem_q[raddr];
endmodule
`default_nettype wire

// ==== verif/dma_far_model.sv ====
// local memory, remote node memory and page table facing the engine
`timescale 1ns/1ns
`default_nettype none
module dma_far_model (
    input  wire logic              ref_clk,
    input  wire dma_pkg::mem_req_t mem_o,
    output dma_pkg::rsp_t          mem_i,
    input  wire dma_pkg::sci_req_t sci_o,
    output dma_pkg::rsp_t          sci_i,
    input  wire logic [11:0]       pt_index,
    output logic      [63:0]       pt_entry,
    input  wire logic [2:0]        slow,
    input  wire logic [31:0]       err_addr
);
    import dma_pkg::*;
    logic [31:0] lmem [1024];
    logic [31:0] rmem [1024];
    logic [2:0]  lcnt;
    logic [2:0]  rcnt;
    // every page is mapped, so a 32-bit job never misses
    assign pt_entry = {32'h0000_00A5, 8'h00, pt_index, 12'h000};
    initial begin
        mem_i = '0;
        sci_i = '0;
        lcnt = '0;
        rcnt = '0;
    end
    // idle read data toggles so a stale word is never mistaken for an answer
    always @(posedge ref_clk) begin
        mem_i.ack <= 1'b0;
        mem_i.err <= 1'b0;
        mem_i.rdata <= ~mem_i.rdata;
        lcnt <= mem_o.req ? lcnt + 3'h1 : 3'h0;
        if (mem_o.req && mem_i.ack) begin
            lcnt <= 3'h0;
            if (mem_o.we)
                lmem[mem_o.addr[11:2]] <= mem_o.wdata;
        end else if (mem_o.req && lcnt >= slow) begin
            mem_i.ack <= 1'b1;
            mem_i.err <= (mem_o.addr == err_addr);
            mem_i.rdata <= lmem[mem_o.addr[11:2]];
        end
    end
    always @(posedge ref_clk) begin
        sci_i.ack <= 1'b0;
        sci_i.err <= 1'b0;
        sci_i.rdata <= ~sci_i.rdata;
        rcnt <= sci_o.req ? rcnt + 3'h1 : 3'h0;
        if (sci_o.req && sci_i.ack) begin
            rcnt <= 3'h0;
            if (sci_o.we)
                rmem[sci_o.addr[11:2]] <= sci_o.wdata;
        end else if (sci_o.req && rcnt >= slow) begin
            sci_i.ack <= 1'b1;
            sci_i.rdata <= rmem[sci_o.addr[11:2]];
        end
    end
endmodule
`default_nettype wire

// ==== verif/test_dma_engine.sv ====
// self-checking bench for the chained dma engine
`timescale 1ns/1ns
`default_nettype none
module test_dma_engine;
    import dma_pkg::*;
    logic        ref_clk, rst_n, reg_wr, reg_rd, bus_hold, irq, big_seen;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, err_addr, hi_seen;
    logic [11:0] pt_index;
    logic [63:0] pt_entry;
    logic [3:0]  win_seen;
    logic [2:0]  slow, cmb_seen;
    logic        hold_q;
    mem_req_t    mem_o;
    sci_req_t    sci_o;
    rsp_t        mem_i, sci_i;
    int          n_errors = 0;
    int          num_checks = 0;
    int          hold_falls = 0;

    dma_engine dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .mem_o(mem_o), .mem_i(mem_i), .sci_o(sci_o),
        .sci_i(sci_i), .pt_index(pt_index), .pt_entry(pt_entry),
        .bus_hold(bus_hold), .xfer_engine_irq_flag(irq));
    dma_far_model m_u (.ref_clk(ref_clk), .mem_o(mem_o), .mem_i(mem_i),
        .sci_o(sci_o), .sci_i(sci_i), .pt_index(pt_index),
        .pt_entry(pt_entry), .slow(slow), .err_addr(err_addr));

    always #2 ref_clk = ~ref_clk;
    // per-job record; a command write clears big_seen and hold_falls
    always @(posedge ref_clk) begin
        hold_q <= bus_hold;
        if (reg_wr && reg_addr == OFF_CMD) begin
            big_seen <= 1'b0;
            hold_falls <= 0;
        end else if (hold_q && !bus_hold) begin
            hold_falls <= hold_falls + 1;
        end
        if (sci_o.req && sci_i.ack) begin
            big_seen <= big_seen | sci_o.big;
            win_seen <= sci_o.win;
            cmb_seen <= sci_o.cmb;
            hi_seen <= sci_o.addr[63:32];
        end
    end

    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // polls status instead of waiting a fixed time: job length varies
    task automatic run_job(input logic [31:0] cmd, output logic [31:0] st);
        wr(OFF_CMD, cmd);
        for (int i = 0; i < 400; i++) begin
            rd(OFF_STATUS, st);
            if (st[ST_ACTIVE] === 1'b0)
                break;
        end
        chk(st[ST_ACTIVE], 1'b0, "job finished");
    endtask
    task automatic single(input logic [31:0] rem, loc, ctl, base,
                          output logic [31:0] st);
        wr(OFF_REMOTE, rem);
        wr(OFF_WBASE, base);
        wr(OFF_LOCAL, loc);
        wr(OFF_CTRL, ctl);
        run_job(32'h0000_0001, st);
    endtask

    task automatic t_reset();
        logic [31:0] v;
        rd(OFF_STATUS, v);
        chk(v, RST_WORD, "status after reset");
        rd(8'h1C, v);
        chk(v, RST_WORD, "unmapped read");
        chk(irq, 1'b0, "irq after reset");
        chk(bus_hold, 1'b0, "bus free after reset");
        $display("test reset done");
    endtask
    task automatic t_push();
        logic [31:0] st;
        single(32'h0000_0200, 32'h0000_0100, 32'h0000_000F
               | (32'h5 << CTRL_WIN_LO) | (32'h3 << CTRL_CMB_LO)
               | (32'h1 << CTRL_WIDE), 32'h1234_5678, st);
        for (int i = 0; i < 16; i++)
            chk(m_u.rmem[10'h80 + i], m_u.lmem[10'h40 + i], "push");
        chk(big_seen, 1'b1, "64-byte packets");
        chk(win_seen, 4'h5, "window");
        chk(cmb_seen, 3'h3, "combining");
        chk(hold_falls, 1, "one packet");
        chk(hi_seen, 32'h1234_5678, "wide base");
        chk(st[ST_DONE:ST_ACTIVE], 3'b100, "push status");
        chk(irq, 1'b0, "no irq programmed");
        $display("test push done");
    endtask
    task automatic t_pull_loop();
        logic [31:0] st;
        single(32'h0000_0304, 32'h0000_0504,
               32'h0000_0002 | (32'h1 << CTRL_PULL), 32'h0, st);
        for (int i = 0; i < 3; i++)
            chk(m_u.lmem[10'h141 + i], m_u.rmem[10'hC1 + i], "pull");
        chk(big_seen, 1'b0, "unaligned small");
        chk(hi_seen, 32'h0000_00A5, "page table");
        chk(hold_falls, 3, "yield per packet");
        single(32'h0000_0680, 32'h0000_0600,
               32'h0000_0001 | (32'h1 << CTRL_LOOP)
               | (32'h1 << CTRL_IRQ_BLK), 32'h0, st);
        for (int i = 0; i < 2; i++)
            chk(m_u.lmem[10'h1A0 + i], m_u.lmem[10'h180 + i], "loop");
        chk(st[ST_DONE:ST_ACTIVE], 3'b100, "loop status");
        chk(irq, 1'b1, "block irq");
        chk(hold_falls, 2, "loop yield");
        wr(OFF_STATUS, 32'h0000_0008);
        $display("test pull and loop done");
    endtask
    task automatic t_chain();
        logic [31:0] st;
        slow = 3'h2;
        m_u.lmem[10'h200] = 32'h0000_0000;
        m_u.lmem[10'h201] = 32'h0000_0040;
        m_u.lmem[10'h202] = 32'h0000_0000;
        m_u.lmem[10'h203] = 32'h0000_0000;
        m_u.lmem[10'h204] = 32'h0000_0020;
        m_u.lmem[10'h205] = 32'h0000_00A0;
        m_u.lmem[10'h206] = (32'h1 << CTRL_LOOP) | (32'h1 << CTRL_EOC)
                            | (32'h1 << CTRL_IRQ_END);
        m_u.lmem[10'h209] = 32'h0000_00C0;
        wr(OFF_LPTR, 32'h0000_0800);
        run_job(32'h0000_0003, st);
        chk(m_u.rmem[10'h10], m_u.lmem[10'h0], "first block");
        chk(m_u.lmem[10'h28], m_u.lmem[10'h8], "next block");
        chk(m_u.rmem[10'h30], 32'h2000_0030, "past end of chain");
        chk({irq, st[ST_IRQ]}, 2'b11, "chain end irq");
        wr(OFF_STATUS, 32'h0000_0008);
        rd(OFF_STATUS, st);
        chk({irq, st[ST_IRQ]}, 2'b00, "irq cleared");
        slow = 3'h0;
        $display("test chain done");
    endtask
    task automatic t_error();
        logic [31:0] st;
        err_addr = 32'h0000_0404;
        single(32'h0000_0700, 32'h0000_0400,
               32'h0000_0003 | (32'h1 << CTRL_IRQ_ERR), 32'h0, st);
        chk(m_u.rmem[10'h1C0], m_u.lmem[10'h100], "before fault");
        chk(m_u.rmem[10'h1C1], 32'h2000_01C1, "halted");
        chk(st[ST_ERROR:ST_ACTIVE], 2'b10, "error status");
        chk(irq, 1'b1, "error irq");
        err_addr = 32'hFFFF_FFFF;
        $display("test error done");
    endtask

    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        slow = 3'h0;
        err_addr = 32'hFFFF_FFFF;
        for (int i = 0; i < 1024; i++) begin
            m_u.lmem[i] = 32'h1000_0000 + i;
            m_u.rmem[i] = 32'h2000_0000 + i;
        end
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_push();
        t_pull_loop();
        t_chain();
        t_error();
        test_done();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        test_done();
    end
endmodule
`default_nettype wire
